/* File: pmc_pkg.sv */
// Purpose: shared constants for the performance monitor counters
// Assumes: special-register numbers select the registers
// Notes:   control bit numbers count from the lsb (bit 0 = lsb)
package pmc_pkg;
	localparam logic [9:0]  PMC_SPR_CTR1   = 10'h3B9;
	localparam logic [9:0]  PMC_SPR_CTR2   = 10'h3BA;
	localparam logic [9:0]  PMC_SPR_CTRL   = 10'h3B8;
	// lsb-numbered positions inside the control word
	localparam int          PMC_B_DIS      = 31;
	localparam int          PMC_B_IRQ_EN   = 26;
	localparam int          PMC_B_FREEZE   = 25;
	localparam int          PMC_B_TBSEL    = 23;
	localparam int          PMC_B_TB_IRQ   = 22;
	localparam int          PMC_B_THRESH   = 16;
	localparam int          PMC_B_C1_IRQ   = 15;
	localparam int          PMC_B_C2_IRQ   = 14;
	localparam int          PMC_B_C2_HOLD  = 13;
	localparam int          PMC_B_SEL1     = 6;
	localparam int          PMC_B_SEL2     = 0;
	localparam logic [31:0] PMC_CTRL_RST   = 32'h0000_0000;
	localparam logic [31:0] PMC_CTR_RST    = 32'h0000_0000;
	localparam int          PMC_N_EV1      = 25;
	localparam int          PMC_N_EV2      = 21;
	localparam int          PMC_EV_CYCLES  = 1;
	localparam int          PMC_EV_TB_EDGE = 3;
	localparam logic [1:0]  PMC_TB_63      = 2'h0;
	localparam logic [1:0]  PMC_TB_55      = 2'h1;
	localparam logic [1:0]  PMC_TB_51      = 2'h2;
	localparam int          PMC_TB_BIT63   = 63;
	localparam int          PMC_TB_BIT55   = 55;
	localparam int          PMC_TB_BIT51   = 51;
	localparam int          PMC_TB_BIT47   = 47;
endpackage : pmc_pkg

/* File: pmc_counter.sv */
// Purpose: one 32-bit event counter with software load
// Assumes: inc and wr never both needed in one cycle; write wins
// Notes:   msb set means negative
`timescale 1ns/100ps
module pmc_counter
#(
	parameter int WIDTH = 32
)
(
	input  wire logic             clk,
	input  wire logic             rst_b,
	input  wire logic             inc,
	input  wire logic             wr,
	input  wire logic [WIDTH-1:0] wdata,
	output      logic [WIDTH-1:0] count_r,
	output      logic             neg
);
	import pmc_pkg::*;
	logic [WIDTH-1:0] count_nxt;

	always_comb
	begin
		count_nxt = count_r;
		if (wr)
			count_nxt = wdata;
		else if (inc)
			count_nxt = count_r + {{(WIDTH-1){1'b0}}, 1'b1};
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
			count_r <= PMC_CTR_RST[WIDTH-1:0];
		else
			count_r <= count_nxt;
	end

	// sign bit is the negative flag
	assign neg = count_r[WIDTH-1];
endmodule : pmc_counter

/* File: pmc_monitor.sv */
// Purpose: performance monitor: control register, two counters, interrupt
// Assumes: spr port is single-cycle; events are one-cycle-per-count strobes
// Notes:   time base is supplied from outside as 64 bits
//
// Operation
// R1: time-base rising edge interrupts when enabled
// R2: edge enable changed only by software
// R3: six-bit threshold stores every value
// R4: counter one negative interrupt enable
// R5: counter two enable overrides freeze
// R6: trigger hold freezes counter two
// R7: seven-bit event select for counter one
// R8: six-bit event select for counter two
// R9: two independent 32-bit event counters
// R10: negative means msb set
// R11: interrupt needs counter enable and global
// R12: interrupt taken only when external enabled
// R13: freeze stops counters after interrupt
// R14: counters reached as special registers
// R15: software loads only non-negative values
// R16: count from control write until interrupt
// R17: codes 0-4 basic events
// R18: codes 5-8 miss and branch events
// R19: threshold dcache miss codes
// R20: codes 11-15 sync and completion events
// R21: codes 16-22 unit result events
// R22: unassigned codes count nothing
// R23: hardware clears global enable on interrupt
// R24: time-base bit selection 63/55/51/47
// R25: freeze keeps counter two if held
`timescale 1ns/100ps
module pmc_monitor
#(
	parameter int CW = 32
)
(
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        spr_wr,
	input  wire logic [9:0]  spr_num,
	input  wire logic [31:0] spr_wdata,
	input  wire logic [63:0] time_base,
	input  wire logic        external_irq_enable,
	input  wire logic [pmc_pkg::PMC_N_EV1-1:0] ev1_in,
	input  wire logic [pmc_pkg::PMC_N_EV2-1:0] ev2_in,
	input  wire logic        thresh_exceeded,
	output      logic [31:0] spr_rdata_ctrl_r,
	output      logic [31:0] spr_rdata_ctr1_r,
	output      logic [31:0] spr_rdata_ctr2_r,
	output      logic [5:0]  threshold_r,
	output      logic        irq_r
);
	import pmc_pkg::*;

	// ----------------------------------------------------------
	// control register
	// ----------------------------------------------------------
	logic [31:0] monitor_control_reg_r;
	logic [31:0] monitor_control_reg_nxt;
	logic        tb_prev_r;
	logic        tb_prev_nxt;
	logic        frozen_r;
	logic        frozen_nxt;
	logic        pend_r;
	logic        pend_nxt;
	logic        irq_nxt;
	logic        monitor_irq_en;
	logic        freeze_on_irq;
	logic        timebase_edge_irq_en;
	logic        ctr1_neg_irq_en;
	logic        ctr2_neg_irq_en;
	logic        ctr2_trigger_hold;
	logic [1:0]  timebase_bit_sel;
	logic [6:0]  ctr1_event_sel;
	logic [5:0]  ctr2_event_sel;
	logic        tb_bit;
	logic        tb_edge;
	logic        signal_irq;
	logic        ctrl_wr;
	logic        c1_wr;
	logic        c2_wr;
	logic        c1_inc;
	logic        c2_inc;
	logic        c1_neg;
	logic        c2_neg;
	logic        ev1_hit;
	logic        ev2_hit;
	logic [31:0] c1_count;
	logic [31:0] c2_count;

	assign monitor_irq_en       = monitor_control_reg_r[PMC_B_IRQ_EN];
	assign freeze_on_irq        = monitor_control_reg_r[PMC_B_FREEZE];
	// R2: software-only bit
	assign timebase_edge_irq_en = monitor_control_reg_r[PMC_B_TB_IRQ];
	assign ctr1_neg_irq_en      = monitor_control_reg_r[PMC_B_C1_IRQ];
	assign ctr2_neg_irq_en      = monitor_control_reg_r[PMC_B_C2_IRQ];
	assign ctr2_trigger_hold    = monitor_control_reg_r[PMC_B_C2_HOLD];
	assign timebase_bit_sel     = monitor_control_reg_r[PMC_B_TBSEL +: 2];
	// R7: counter one selector
	assign ctr1_event_sel       = monitor_control_reg_r[PMC_B_SEL1 +: 7];
	// R8: counter two selector
	assign ctr2_event_sel       = monitor_control_reg_r[PMC_B_SEL2 +: 6];

	// R14: special-register decode
	assign ctrl_wr = spr_wr && (spr_num == PMC_SPR_CTRL);
	assign c1_wr   = spr_wr && (spr_num == PMC_SPR_CTR1);
	assign c2_wr   = spr_wr && (spr_num == PMC_SPR_CTR2);

	// ----------------------------------------------------------
	// time-base edge
	// ----------------------------------------------------------
	// R24: bit selection
	always_comb
	begin
		if (timebase_bit_sel == PMC_TB_63)
			tb_bit = time_base[PMC_TB_BIT63];
		else if (timebase_bit_sel == PMC_TB_55)
			tb_bit = time_base[PMC_TB_BIT55];
		else if (timebase_bit_sel == PMC_TB_51)
			tb_bit = time_base[PMC_TB_BIT51];
		else
			tb_bit = time_base[PMC_TB_BIT47];
	end
	assign tb_edge = tb_bit && !tb_prev_r;

	// ----------------------------------------------------------
	// interrupt condition
	// ----------------------------------------------------------
	// R1: edge interrupt gated by enable
	// R4: counter one gate
	// R5: counter two gate
	// R10: sign bit is negative
	// R11: needs global enable too
	assign signal_irq = monitor_irq_en &&
		((timebase_edge_irq_en && tb_edge) ||
		 (ctr1_neg_irq_en && c1_neg) ||
		 (ctr2_neg_irq_en && c2_neg));

	always_comb
	begin
		monitor_control_reg_nxt = monitor_control_reg_r;
		frozen_nxt              = frozen_r;
		pend_nxt                = pend_r;
		tb_prev_nxt             = tb_bit;
		irq_nxt                 = 1'b0;
		// R16: new control restarts counting
		if (ctrl_wr)
		begin
			monitor_control_reg_nxt = spr_wdata;
			frozen_nxt              = 1'b0;
		end
		if (signal_irq)
		begin
			// R23: hardware drops global enable
			monitor_control_reg_nxt[PMC_B_IRQ_EN] = 1'b0;
			// R13: freeze after interrupt
			if (freeze_on_irq)
				frozen_nxt = 1'b1;
			pend_nxt = 1'b1;
		end
		// R12: wait for external enable
		if (pend_r && external_irq_enable)
		begin
			irq_nxt  = 1'b1;
			pend_nxt = signal_irq;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			monitor_control_reg_r <= PMC_CTRL_RST;
			frozen_r              <= 1'b0;
			pend_r                <= 1'b0;
			tb_prev_r             <= 1'b0;
			irq_r                 <= 1'b0;
		end
		else
		begin
			monitor_control_reg_r <= monitor_control_reg_nxt;
			frozen_r              <= frozen_nxt;
			pend_r                <= pend_nxt;
			tb_prev_r             <= tb_prev_nxt;
			irq_r                 <= irq_nxt;
		end
	end

	// ----------------------------------------------------------
	// event selection
	// ----------------------------------------------------------
	// R17: codes 0-4; R18: 5-8; R19: threshold misses
	// R20: 11-15; R21: 16-22; R22: others idle
	always_comb
	begin
		ev1_hit = 1'b0;
		// cycles are the block's own clock, so no strobe is needed for them
		if (ctr1_event_sel == 7'(PMC_EV_CYCLES))
			ev1_hit = 1'b1;
		else if (ctr1_event_sel == 7'h03)
			ev1_hit = tb_edge;
		else if ((ctr1_event_sel == 7'h09) || (ctr1_event_sel == 7'h0A) ||
			 (ctr1_event_sel == 7'h17) || (ctr1_event_sel == 7'h18))
			ev1_hit = ev1_in[ctr1_event_sel[4:0]] && thresh_exceeded;
		else if ((ctr1_event_sel != 7'h00) && (ctr1_event_sel < 7'(PMC_N_EV1)))
			ev1_hit = ev1_in[ctr1_event_sel[4:0]];
	end

	always_comb
	begin
		ev2_hit = 1'b0;
		if (ctr2_event_sel == 6'(PMC_EV_CYCLES))
			ev2_hit = 1'b1;
		else if (ctr2_event_sel == 6'h03)
			ev2_hit = tb_edge;
		else if ((ctr2_event_sel != 6'h00) && (ctr2_event_sel < 6'(PMC_N_EV2)))
			ev2_hit = ev2_in[ctr2_event_sel[4:0]];
	end

	// R6: trigger hold until counter one negative or interrupt
	// R25: held counter two ignores freeze
	// R5: enable overrides freeze for counter two
	assign c1_inc = ev1_hit && !frozen_r && !monitor_control_reg_r[PMC_B_DIS];
	assign c2_inc = ev2_hit && !monitor_control_reg_r[PMC_B_DIS] &&
		(ctr2_trigger_hold ? (c1_neg || pend_r || frozen_r)
		                   : (!frozen_r || ctr2_neg_irq_en));

	// ----------------------------------------------------------
	// counters
	// ----------------------------------------------------------
	// R9: two independent counters
	// R15: software avoids negative loads
	pmc_counter #(.WIDTH(CW)) u_ctr1
	(
		.clk     (clk),
		.rst_b   (rst_b),
		.inc     (c1_inc),
		.wr      (c1_wr),
		.wdata   (spr_wdata),
		.count_r (c1_count),
		.neg     (c1_neg)
	);

	pmc_counter #(.WIDTH(CW)) u_ctr2
	(
		.clk     (clk),
		.rst_b   (rst_b),
		.inc     (c2_inc),
		.wr      (c2_wr),
		.wdata   (spr_wdata),
		.count_r (c2_count),
		.neg     (c2_neg)
	);

	// ----------------------------------------------------------
	// read-back outputs
	// ----------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			spr_rdata_ctrl_r <= PMC_CTRL_RST;
			spr_rdata_ctr1_r <= PMC_CTR_RST;
			spr_rdata_ctr2_r <= PMC_CTR_RST;
			threshold_r      <= 6'h00;
		end
		else
		begin
			spr_rdata_ctrl_r <= monitor_control_reg_nxt;
			spr_rdata_ctr1_r <= c1_count;
			spr_rdata_ctr2_r <= c2_count;
			// R3: full six-bit threshold
			threshold_r      <= monitor_control_reg_r[PMC_B_THRESH +: 6];
		end
	end

	// ----------------------------------------------------------
	// assertions
	// ----------------------------------------------------------
	property p_en_cleared;
		@(posedge clk) disable iff (!rst_b) signal_irq |=> !monitor_irq_en;
	endproperty
	a_en_cleared: assert property (p_en_cleared) else $error("enable not cleared"); // R23

	property p_no_irq_without_en;
		@(posedge clk) disable iff (!rst_b) !monitor_irq_en |-> !signal_irq;
	endproperty
	a_no_irq_without_en: assert property (p_no_irq_without_en) else $error("irq while off"); // R11

	property p_ee_wait;
		@(posedge clk) disable iff (!rst_b) !external_irq_enable |=> !irq_r;
	endproperty
	a_ee_wait: assert property (p_ee_wait) else $error("irq taken while masked"); // R12

	property p_pend_taken;
		@(posedge clk) disable iff (!rst_b)
			(pend_r && external_irq_enable) |=> irq_r;
	endproperty
	a_pend_taken: assert property (p_pend_taken) else $error("pending irq lost"); // R12

	property p_freeze;
		@(posedge clk) disable iff (!rst_b)
			(signal_irq && freeze_on_irq && !ctrl_wr) |=> !c1_inc;
	endproperty
	a_freeze: assert property (p_freeze) else $error("counter one ran frozen"); // R13

	property p_c1_count;
		@(posedge clk) disable iff (!rst_b)
			(c1_inc && !c1_wr) |=> (c1_count == $past(c1_count) + 32'h1);
	endproperty
	a_c1_count: assert property (p_c1_count) else $error("counter one no step"); // R9

	property p_hold;
		@(posedge clk) disable iff (!rst_b)
			(ctr2_trigger_hold && !c1_neg && !pend_r && !frozen_r) |-> !c2_inc;
	endproperty
	a_hold: assert property (p_hold) else $error("held counter two ran"); // R6

	property p_sel_zero;
		@(posedge clk) disable iff (!rst_b) (ctr1_event_sel == 7'h00) |-> !c1_inc;
	endproperty
	a_sel_zero: assert property (p_sel_zero) else $error("nothing code counted"); // R17

	property p_wr_load;
		@(posedge clk) disable iff (!rst_b) c2_wr |=> (c2_count == $past(spr_wdata));
	endproperty
	a_wr_load: assert property (p_wr_load) else $error("counter two load lost"); // R14

	c_irq: cover property (@(posedge clk) disable iff (!rst_b) irq_r);
	c_tb: cover property (@(posedge clk) disable iff (!rst_b) tb_edge && timebase_edge_irq_en);
	c_c2neg: cover property (@(posedge clk) disable iff (!rst_b) c2_neg && c2_inc);
endmodule : pmc_monitor

/* File: pmc_core_model.sv */
// Purpose: core-side source of event strobes and time base, irq counter
// Assumes: strobes change at the falling clock edge
// Notes:   one strobe every two cycles, so each one is a clean pulse
`timescale 1ns/100ps
module pmc_core_model
(
	input  wire logic                          clk,
	input  wire logic                          irq_r,
	output      logic [pmc_pkg::PMC_N_EV1-1:0] ev1_in,
	output      logic [pmc_pkg::PMC_N_EV2-1:0] ev2_in,
	output      logic [63:0]                   time_base
);
	import pmc_pkg::*;
	int irq_cnt = 0;
	initial
	begin
		ev1_in = '0;
		ev2_in = '0;
		time_base = '0;
	end
	always @(posedge clk)
		if (irq_r === 1'b1)
			irq_cnt++;
	// ----------------------------------------
	// strobes: negative index means none
	// ----------------------------------------
	task automatic pulse(input int c1, input int c2, input int n);
		repeat (n)
		begin
			@(negedge clk);
			if (c1 >= 0)
				ev1_in[c1] = 1'b1;
			if (c2 >= 0)
				ev2_in[c2] = 1'b1;
			@(negedge clk);
			ev1_in = '0;
			ev2_in = '0;
		end
	endtask : pulse
	task automatic tb_set(input logic [63:0] v);
		@(negedge clk);
		time_base = v;
	endtask : tb_set
endmodule : pmc_core_model

/* File: testbench.sv */
// Purpose: self-checking bench for the performance monitor
// Assumes: register access through the special-register write port
// Notes:   read outputs are sampled after they have settled
`timescale 1ns/100ps
module testbench;
	import pmc_pkg::*;
	localparam logic [31:0] M_EN = 32'h1 << PMC_B_IRQ_EN;
	localparam logic [31:0] M_FR = 32'h1 << PMC_B_FREEZE;
	localparam logic [31:0] M_TB = 32'h1 << PMC_B_TB_IRQ;
	localparam logic [31:0] M_C1 = 32'h1 << PMC_B_C1_IRQ;
	localparam logic [31:0] M_C2 = 32'h1 << PMC_B_C2_IRQ;
	localparam logic [31:0] M_HD = 32'h1 << PMC_B_C2_HOLD;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        spr_wr = 1'b0;
	logic [9:0]  spr_num = '0;
	logic [31:0] spr_wdata = '0;
	logic        ext = 1'b0;
	logic        thr = 1'b0;
	logic [31:0] rc, r1, r2, v;
	logic [5:0]  th;
	logic        irq;
	logic [24:0] ev1;
	logic [20:0] ev2;
	logic [63:0] tb;
	int          err_total = 0;
	int          cmp_count = 0;
	int          cyc = 0;
	int          n0, c2, bt[4];
	always #20 clk = ~clk;
	pmc_monitor uut (.clk(clk), .rst_b(rst_b), .spr_wr(spr_wr), .spr_num(spr_num),
		.spr_wdata(spr_wdata), .time_base(tb), .external_irq_enable(ext),
		.ev1_in(ev1), .ev2_in(ev2), .thresh_exceeded(thr), .spr_rdata_ctrl_r(rc),
		.spr_rdata_ctr1_r(r1), .spr_rdata_ctr2_r(r2), .threshold_r(th), .irq_r(irq));
	pmc_core_model core (.clk(clk), .irq_r(irq), .ev1_in(ev1), .ev2_in(ev2),
		.time_base(tb));
	// ----------------------------------------
	// access and compare tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			err_total++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [9:0] n, input logic [31:0] d);
		@(negedge clk);
		spr_wr = 1'b1;
		spr_num = n;
		spr_wdata = d;
		@(negedge clk);
		spr_wr = 1'b0;
	endtask : wr
	// registered copies lag by up to two edges
	task automatic rd(input logic [9:0] n, output logic [31:0] d);
		repeat (3) @(negedge clk);
		d = (n == PMC_SPR_CTRL) ? rc : (n == PMC_SPR_CTR1) ? r1 : r2;
	endtask : rd
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : tally_and_finish
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_total++;
			$display("[ERR] %0t run did not finish", $time);
			tally_and_finish;
		end
	end
	initial
	begin
		bt = '{PMC_TB_BIT63, PMC_TB_BIT55, PMC_TB_BIT51, PMC_TB_BIT47};
		repeat (4) @(negedge clk);
		rst_b = 1'b1;
		chk(rc, PMC_CTRL_RST);
		chk(r1 | r2, PMC_CTR_RST);
		wr(PMC_SPR_CTRL, 32'h81BF_156A);
		rd(PMC_SPR_CTRL, v);
		chk(v, 32'h81BF_156A);
		chk({26'h0, th}, 32'h3F);
		wr(PMC_SPR_CTR1, 32'h1234_5678);
		wr(PMC_SPR_CTR2, 32'h0BCD_EF01);
		wr(10'h3BB, 32'h5555_5555);
		rd(PMC_SPR_CTR1, v);
		chk(v, 32'h1234_5678);
		chk(r2, 32'h0BCD_EF01);
		chk(rc, 32'h81BF_156A);
		// every assigned code except cycles and time-base edges
		thr = 1'b1;
		for (int c = 2; c < PMC_N_EV1; c++)
			if (c != PMC_EV_TB_EDGE)
			begin
				c2 = (c < PMC_N_EV2) ? c : 0;
				wr(PMC_SPR_CTRL, (c << PMC_B_SEL1) | c2);
				wr(PMC_SPR_CTR1, 32'h0);
				wr(PMC_SPR_CTR2, 32'h0);
				core.pulse(c, c2, 3);
				rd(PMC_SPR_CTR1, v);
				chk(v, 32'h3);
				chk(r2, (c2 == 0) ? 32'h0 : 32'h3);
			end
		wr(PMC_SPR_CTR1, 32'h0);
		wr(PMC_SPR_CTRL, (32'h64 << PMC_B_SEL1) | 32'h30);
		core.pulse(4, 16, 2);
		rd(PMC_SPR_CTR1, v);
		chk(v | r2, 32'h0);
		thr = 1'b0;
		wr(PMC_SPR_CTRL, 32'h9 << PMC_B_SEL1);
		core.pulse(9, -1, 2);
		rd(PMC_SPR_CTR1, v);
		chk(v, 32'h0);
		wr(PMC_SPR_CTRL, 32'h1 << PMC_B_SEL1);
		rd(PMC_SPR_CTR1, v);
		repeat (10) @(negedge clk);
		chk(r1, v + 32'hA);
		// negative without counter enable; hold lifts on counter one sign
		ext = 1'b1;
		wr(PMC_SPR_CTRL, M_EN | M_HD | (32'h2 << PMC_B_SEL1) | 32'h2);
		wr(PMC_SPR_CTR1, 32'h7FFF_FFFF);
		wr(PMC_SPR_CTR2, 32'h0);
		n0 = core.irq_cnt;
		core.pulse(-1, 2, 2);
		rd(PMC_SPR_CTR2, v);
		chk(v, 32'h0);
		core.pulse(2, -1, 1);
		core.pulse(-1, 2, 2);
		rd(PMC_SPR_CTR1, v);
		chk(v, 32'h8000_0000);
		chk(r2, 32'h2);
		chk(core.irq_cnt, n0);
		// pending interrupt, global enable cleared, freeze
		ext = 1'b0;
		wr(PMC_SPR_CTR1, 32'h7FFF_FFFF);
		wr(PMC_SPR_CTR2, 32'h0);
		wr(PMC_SPR_CTRL, M_EN | M_C1 | M_FR | M_HD | (32'h2 << PMC_B_SEL1) | 32'h2);
		core.pulse(2, -1, 1);
		repeat (10) @(negedge clk);
		chk(core.irq_cnt, n0);
		chk(rc & M_EN, 32'h0);
		ext = 1'b1;
		repeat (5) @(negedge clk);
		chk(core.irq_cnt, n0 + 1);
		core.pulse(2, 2, 2);
		rd(PMC_SPR_CTR1, v);
		chk(v, 32'h8000_0000);
		chk(r2, 32'h2);
		// counter two negative enable keeps it running through a freeze
		wr(PMC_SPR_CTR1, 32'h7FFF_FFFF);
		wr(PMC_SPR_CTR2, 32'h0);
		wr(PMC_SPR_CTRL, M_EN | M_C1 | M_C2 | M_FR | (32'h2 << PMC_B_SEL1) | 32'h2);
		core.pulse(2, -1, 1);
		repeat (5) @(negedge clk);
		core.pulse(2, 2, 2);
		rd(PMC_SPR_CTR1, v);
		chk(v, 32'h8000_0000);
		chk(r2, 32'h2);
		// time-base bit selection, edge interrupt and edge count
		for (int s = 0; s < 4; s++)
		begin
			core.tb_set(64'h0);
			wr(PMC_SPR_CTR1, 32'h0);
			wr(PMC_SPR_CTRL, M_EN | M_TB | (s << PMC_B_TBSEL) | (32'h3 << PMC_B_SEL1));
			n0 = core.irq_cnt;
			core.tb_set(64'h1 << bt[(s + 1) % 4]);
			repeat (5) @(negedge clk);
			chk(core.irq_cnt, n0);
			core.tb_set(tb | (64'h1 << bt[s]));
			repeat (5) @(negedge clk);
			chk(core.irq_cnt, n0 + 1);
			rd(PMC_SPR_CTR1, v);
			chk(v, 32'h1);
			chk(rc & M_TB, M_TB);
		end
		core.tb_set(64'h0);
		wr(PMC_SPR_CTRL, M_EN);
		n0 = core.irq_cnt;
		core.tb_set(64'h1 << PMC_TB_BIT63);
		repeat (5) @(negedge clk);
		chk(core.irq_cnt, n0);
		tally_and_finish;
	end
endmodule : testbench
